// >>> core/warc_pkg.sv
// Purpose: Shared constants and types for the watchdog and reset control.
// Assumes: Registers sit on a 32-bit APB slave, one aligned word each.
// Notes:   Field positions, reset values and key codes live here only.
package warc_pkg;

  // ----------------------------------------------------------------------
  // Register map and bus widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_WDT_CTL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LVL_KEY = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_BO_WIDTH = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions and power-on values
  // ----------------------------------------------------------------------
  localparam int KEY_MSB = 7;
  localparam int KEY_LSB = 3;
  localparam int TSEL_MSB = 2;
  localparam int TSEL_LSB = 0;
  localparam logic [7:0] WDT_CTL_POR = 8'h53;
  localparam logic [4:0] KEY_ENABLE = 5'h0a;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [7:0] LVL_KEY_POR = 8'h66;
  localparam logic [5:0][7:0] LVL_KEY_OK = {8'hf0, 8'haa, 8'h99, 8'h33,
                                            8'h55, 8'h66};
  localparam logic [1:0] BO_WIDTH_POR = 2'h1;
  localparam int FLG_KEY = 0;
  localparam int FLG_LVL = 1;
  localparam int FLG_BO = 2;
  localparam int STS_EXPIRY = 0;
  localparam int STS_PDOWN = 1;

  // ----------------------------------------------------------------------
  // Counter sizes and tables, counted in slow oscillator periods
  // ----------------------------------------------------------------------
  localparam int WDT_W = 19;
  localparam logic [7:0][4:0] TSEL_BIT = {5'h12, 5'h11, 5'h10, 5'h0f,
                                          5'h0e, 5'h0c, 5'h0a, 5'h08};
  localparam logic [3:0][7:0] BO_WIDTH = {8'h80, 8'h40, 8'h20, 8'h08};
  localparam logic [7:0] BO_CNT_MAX = 8'hff;
  localparam int SR_CNT_W = 16;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SR_IDLE = 3'b001,
    SR_WAIT = 3'b010,
    SR_FIRE = 3'b100
  } warc_sr_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } warc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } warc_apb_rsp_t;

  typedef struct packed {
    logic clear_watchdog_instr;
    logic halt_instr;
    logic low_power;
  } warc_cpu_evt_t;

  typedef struct packed {
    logic [2:0] osc_sync;
    logic osc_lvl;
    logic [2:0] sup_sync;
    logic sup_lvl;
    logic [7:0] watchdog_control;
    logic [7:0] supply_level_key;
    logic [1:0] brownout_width_select;
    logic key_field_reset_flag;
    logic level_key_reset_flag;
    logic brownout_reset_flag;
    logic expiry_flag;
    logic powerdown_flag;
    logic [WDT_W-1:0] watchdog_counter;
    logic [7:0] bo_cnt;
    warc_sr_t sr;
    logic [SR_CNT_W-1:0] sr_cnt;
    logic sr_key;
    logic sr_lvl;
    warc_apb_rsp_t rsp;
    logic device_reset;
    logic pc_sp_reset;
  } warc_state_t;

endpackage : warc_pkg

// >>> core/warc_top.sv
// Purpose: Watchdog counter, brownout qualification and reset-cause flags.
// Assumes: Slow oscillator and supply-low indication arrive as pins.
// Notes:   Everything runs on clk; the oscillator is sampled for edges.
//
// Overview of operation
// - Watchdog counts slow oscillator periods, not clk.
// - Three-bit select picks overflow from 2^8 to 2^18.
// - Key 10101 disables, key 01010 enables watchdog.
// - Other key value: delayed full reset, flag set.
// - Control register powers up as 01010011.
// - Key-field flag set by hardware, cleared by zero-write.
// - Running overflow gives full reset and expiry flag.
// - Low-power overflow sets flags, resets PC and SP.
// - Counter cleared by bad key, clear, halt.
// - Brownout check active in run modes, fixed level.
// - Brownout check off in idle or sleep.
// - Only supply dips longer than width cause reset.
// - Qualified brownout resets device, sets its flag.
// - Level key accepts six codes, one threshold.
// - Other level key values reset after delay.
// - Invalid level key sets level-key reset flag.
// - Invalid level key reset restores its power-on value.
// - Brownout reset keeps level key contents.
// - Level key powers up as 01100110.
// - Power-on clears PC and presets ports high.
// - Width select gives 8, 32, 64, 128 periods.
// - Brownout flag set by hardware, cleared by software.
// - Powerdown flag set by halt, cleared by clear.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
module warc_top
  import warc_pkg::*;
#(
  parameter int SOFT_RESET_DELAY = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire warc_apb_req_t apb_req,
  output warc_apb_rsp_t apb_rsp,
  input wire logic slow_internal_osc,
  input wire logic supply_low,
  input wire warc_cpu_evt_t cpu_evt,
  output logic device_reset,
  output logic pc_sp_reset,
  output logic expiry_flag,
  output logic powerdown_flag
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (SOFT_RESET_DELAY < 1 || SOFT_RESET_DELAY >= (1 << SR_CNT_W)) begin : g_bad
    $error("SOFT_RESET_DELAY out of range");
  end

  localparam logic [SR_CNT_W-1:0] SR_LAST = SR_CNT_W'(SOFT_RESET_DELAY - 1);

  // Power-on state; device_reset stands high so the core restarts at PC 0
  // with every port data and direction bit preset high.
  localparam warc_state_t STATE_RST = '{
    osc_sync: 3'h0, osc_lvl: 1'b0, sup_sync: 3'h0, sup_lvl: 1'b0,
    watchdog_control: WDT_CTL_POR,
    supply_level_key: LVL_KEY_POR,
    brownout_width_select: BO_WIDTH_POR,
    key_field_reset_flag: 1'b0, level_key_reset_flag: 1'b0,
    brownout_reset_flag: 1'b0, expiry_flag: 1'b0, powerdown_flag: 1'b0,
    watchdog_counter: '0, bo_cnt: 8'h00, sr: SR_IDLE, sr_cnt: '0,
    sr_key: 1'b0, sr_lvl: 1'b0, rsp: '0,
    device_reset: 1'b1,
    pc_sp_reset: 1'b0
  };

  warc_state_t q;
  warc_state_t next_q;

  // Decoded views of the current state, shared with the assertions.
  logic osc_rise;
  logic key_bad;
  logic lvl_bad;
  logic wdt_en;
  logic wdt_ovf;
  logic bo_active;
  logic bo_fire;
  logic wdt_fire;
  logic srst_fire;
  logic full_fire;
  logic bus_wr;
  logic flag_wr;
  logic lvl_wr;
  logic [4:0] key;
  logic [2:0] tsel;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // A slow edge counts once the second and third sync stages agree, so a
  // metastable first stage never reaches the counters.
  always_comb begin
    key = q.watchdog_control[KEY_MSB:KEY_LSB];
    tsel = q.watchdog_control[TSEL_MSB:TSEL_LSB];
    osc_rise = (q.osc_sync[1] == q.osc_sync[2]) && q.osc_sync[2] &&
               !q.osc_lvl;
    wdt_en = (key == KEY_ENABLE);
    key_bad = (key != KEY_ENABLE) && (key != KEY_DISABLE);
    lvl_bad = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (q.supply_level_key == LVL_KEY_OK[i]) begin
        lvl_bad = 1'b0;
      end
    end
    // The selected bit going high is the overflow; changing the select
    // does not clear the count, so a shorter select may expire at once.
    wdt_ovf = wdt_en && q.watchdog_counter[TSEL_BIT[tsel]];
    bo_active = !cpu_evt.low_power;
    bo_fire = bo_active && q.sup_lvl && osc_rise &&
              (q.bo_cnt == BO_WIDTH[q.brownout_width_select] - 8'h01);
    wdt_fire = wdt_ovf && !cpu_evt.low_power;
    srst_fire = (q.sr == SR_FIRE);
    full_fire = bo_fire || wdt_fire || srst_fire;
    bus_wr = apb_req.psel && apb_req.penable && apb_req.pwrite &&
             q.rsp.pready;
    flag_wr = bus_wr && (apb_req.paddr == OFF_FLAGS);
    lvl_wr = bus_wr && (apb_req.paddr == OFF_LVL_KEY);
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.device_reset = 1'b0;
    next_q.pc_sp_reset = 1'b0;
    next_q.rsp = '0;

    // Three-stage synchronisers for the two pins.
    next_q.osc_sync = {q.osc_sync[1:0], slow_internal_osc};
    next_q.sup_sync = {q.sup_sync[1:0], supply_low};
    if (q.osc_sync[1] == q.osc_sync[2]) begin
      next_q.osc_lvl = q.osc_sync[2];
    end
    if (q.sup_sync[1] == q.sup_sync[2]) begin
      next_q.sup_lvl = q.sup_sync[2];
    end

    // APB: the access phase is answered one cycle after it opens, with
    // read data and error ready at that edge.
    if (apb_req.psel && apb_req.penable && !q.rsp.pready) begin
      next_q.rsp.pready = 1'b1;
      unique case (apb_req.paddr)
        OFF_WDT_CTL: next_q.rsp.prdata = {24'h0, q.watchdog_control};
        OFF_FLAGS: next_q.rsp.prdata = {29'h0, q.brownout_reset_flag,
                                        q.level_key_reset_flag,
                                        q.key_field_reset_flag};
        OFF_LVL_KEY: next_q.rsp.prdata = {24'h0, q.supply_level_key};
        OFF_BO_WIDTH: next_q.rsp.prdata = {30'h0, q.brownout_width_select};
        OFF_STATUS: next_q.rsp.prdata = {30'h0, q.powerdown_flag,
                                         q.expiry_flag};
        default: next_q.rsp.pslverr = 1'b1;
      endcase
    end

    // Register writes take effect at the edge where pready is seen high.
    if (bus_wr) begin
      unique case (apb_req.paddr)
        OFF_WDT_CTL: next_q.watchdog_control = apb_req.pwdata[7:0];
        OFF_LVL_KEY: next_q.supply_level_key = apb_req.pwdata[7:0];
        OFF_BO_WIDTH: next_q.brownout_width_select = apb_req.pwdata[1:0];
        default: ;
      endcase
    end
    // Flags only clear on a written zero; a written one is ignored.
    if (flag_wr) begin
      next_q.key_field_reset_flag = q.key_field_reset_flag &
                                    apb_req.pwdata[FLG_KEY];
      next_q.level_key_reset_flag = q.level_key_reset_flag &
                                    apb_req.pwdata[FLG_LVL];
      next_q.brownout_reset_flag = q.brownout_reset_flag &
                                   apb_req.pwdata[FLG_BO];
    end

    // Soft-reset sequencer: a bad key of either kind waits out the delay,
    // then fires one full reset. Causes are latched so a late repair of
    // the key still leaves the right flag behind.
    unique case (q.sr)
      SR_IDLE: begin
        if (key_bad || lvl_bad) begin
          next_q.sr = SR_WAIT;
          next_q.sr_cnt = '0;
          next_q.sr_key = key_bad;
          next_q.sr_lvl = lvl_bad;
        end
      end
      SR_WAIT: begin
        next_q.sr_key = q.sr_key || key_bad;
        next_q.sr_lvl = q.sr_lvl || lvl_bad;
        if (osc_rise) begin
          if (q.sr_cnt == SR_LAST) begin
            next_q.sr = SR_FIRE;
          end else begin
            next_q.sr_cnt = q.sr_cnt + 1'b1;
          end
        end
      end
      SR_FIRE: begin
        next_q.sr = SR_IDLE;
      end
    endcase

    // Watchdog counter on slow edges only.
    if (!wdt_en || key_bad || cpu_evt.clear_watchdog_instr ||
        cpu_evt.halt_instr) begin
      next_q.watchdog_counter = '0;
    end else if (wdt_ovf) begin
      next_q.watchdog_counter = '0;
    end else if (osc_rise) begin
      next_q.watchdog_counter = q.watchdog_counter + 1'b1;
    end

    // Status flags: clears first, sets after, so a set in the same cycle
    // as a clear survives.
    if (cpu_evt.clear_watchdog_instr || cpu_evt.halt_instr) begin
      next_q.expiry_flag = 1'b0;
    end
    if (cpu_evt.clear_watchdog_instr) begin
      next_q.powerdown_flag = 1'b0;
    end
    if (cpu_evt.halt_instr) begin
      next_q.powerdown_flag = 1'b1;
    end
    if (wdt_ovf) begin
      next_q.expiry_flag = 1'b1;
      if (cpu_evt.low_power) begin
        next_q.powerdown_flag = 1'b1;
        next_q.pc_sp_reset = 1'b1;
      end
    end

    // Brownout width counter; it restarts whenever the supply recovers
    // or the device leaves the run modes, so short dips leave no trace.
    if (!bo_active || !q.sup_lvl) begin
      next_q.bo_cnt = 8'h00;
    end else if (osc_rise && q.bo_cnt != BO_CNT_MAX) begin
      next_q.bo_cnt = q.bo_cnt + 8'h01;
    end

    // Full reset: pulse out, restore control state, record the cause.
    if (full_fire) begin
      next_q.device_reset = 1'b1;
      next_q.watchdog_control = WDT_CTL_POR;
      next_q.watchdog_counter = '0;
      next_q.bo_cnt = 8'h00;
      next_q.sr = SR_IDLE;
      next_q.sr_key = 1'b0;
      next_q.sr_lvl = 1'b0;
      // A genuine brownout alone leaves the level key as it was.
      if (wdt_fire || srst_fire) begin
        next_q.supply_level_key = LVL_KEY_POR;
      end
    end
    if (srst_fire && q.sr_key) begin
      next_q.key_field_reset_flag = 1'b1;
    end
    if (srst_fire && q.sr_lvl) begin
      next_q.level_key_reset_flag = 1'b1;
    end
    if (bo_fire) begin
      next_q.brownout_reset_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // The clock enable freezes every field, including the synchronisers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= STATE_RST;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  assign apb_rsp = q.rsp;
  assign device_reset = q.device_reset;
  assign pc_sp_reset = q.pc_sp_reset;
  assign expiry_flag = q.expiry_flag;
  assign powerdown_flag = q.powerdown_flag;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_key_disable_stops: assert property (
    clk_en && key == KEY_DISABLE ##1 clk_en && key == KEY_DISABLE
    |-> q.watchdog_counter == '0)
    else $error("Watchdog counts while disabled.");

  a_bad_key_arms: assert property (
    clk_en && key_bad && q.sr == SR_IDLE && !full_fire
    |=> q.sr == SR_WAIT && q.sr_key)
    else $error("Bad watchdog key did not arm soft reset.");

  a_key_fire_flag: assert property (
    clk_en && srst_fire && q.sr_key
    |=> q.device_reset && q.key_field_reset_flag &&
        q.watchdog_control == WDT_CTL_POR)
    else $error("Key soft reset lost its flag or reset.");

  a_key_flag_sticky: assert property (
    clk_en && q.key_field_reset_flag && !flag_wr
    |=> q.key_field_reset_flag)
    else $error("Key reset flag cleared without a write.");

  a_overflow_normal: assert property (
    clk_en && wdt_fire && !cpu_evt.clear_watchdog_instr &&
    !cpu_evt.halt_instr
    |=> q.device_reset && q.expiry_flag && q.watchdog_counter == '0)
    else $error("Running overflow did not reset the device.");

  a_overflow_sleep: assert property (
    clk_en && wdt_ovf && cpu_evt.low_power && !srst_fire &&
    !cpu_evt.clear_watchdog_instr && !cpu_evt.halt_instr
    |=> q.pc_sp_reset && q.expiry_flag && q.powerdown_flag &&
        !q.device_reset)
    else $error("Low-power overflow handled wrongly.");

  a_clear_counter: assert property (
    clk_en && (cpu_evt.clear_watchdog_instr || cpu_evt.halt_instr)
    |=> q.watchdog_counter == '0)
    else $error("Clear or halt left the watchdog counting.");

  // A bad key still resets in low power, so that case is left out here.
  a_bo_sleep_off: assert property (
    clk_en && cpu_evt.low_power && !srst_fire
    |=> q.bo_cnt == 8'h00 && !q.device_reset)
    else $error("Brownout qualification ran in low power.");

  a_bo_qualify: assert property (
    clk_en && bo_fire |=> q.device_reset && q.brownout_reset_flag)
    else $error("Qualified brownout did not reset.");

  // Only a written zero may clear the brownout cause.
  a_bo_flag_sticky: assert property (
    clk_en && q.brownout_reset_flag && !flag_wr
    |=> q.brownout_reset_flag)
    else $error("Brownout flag cleared without a write.");

  a_lvl_restore: assert property (
    clk_en && srst_fire && q.sr_lvl
    |=> q.supply_level_key == LVL_KEY_POR && q.level_key_reset_flag)
    else $error("Level key not restored after its reset.");

  a_lvl_keep: assert property (
    clk_en && bo_fire && !wdt_fire && !srst_fire && !lvl_wr
    |=> q.supply_level_key == $past(q.supply_level_key))
    else $error("Brownout reset changed the level key.");

  // An overflow in the same cycle sets the expiry flag, and the set wins.
  a_pdown_halt: assert property (
    clk_en && cpu_evt.halt_instr && !wdt_ovf
    |=> q.powerdown_flag && !q.expiry_flag)
    else $error("Halt did not set the powerdown flag.");

  // A low clock enable must hold every field, synchronisers included.
  a_enable_freeze: assert property (
    !clk_en |=> $stable(q))
    else $error("State moved while the clock enable was low.");

  c_key_reset: cover property (clk_en && srst_fire && q.sr_key);
  c_lvl_reset: cover property (clk_en && srst_fire && q.sr_lvl);
  c_sleep_overflow: cover property (clk_en && wdt_ovf && cpu_evt.low_power);
  c_brownout: cover property (clk_en && bo_fire);

endmodule : warc_top

// >>> sim/warc_tb.sv
// Purpose: Self-checking bench for the watchdog and reset control block.
// Assumes: One clock; the bench drives the slow oscillator and supply pins.
// Notes:   Soft-reset delay shrunk to 2 slow periods to keep the run short.
`timescale 1ns/1ns
module warc_tb
  import warc_pkg::*;
();
  localparam int SRD = 2;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic osc = 1'b0;
  logic sup = 1'b0;
  warc_apb_req_t req = '0;
  warc_apb_rsp_t rsp;
  warc_cpu_evt_t cpu = '0;
  logic dev_rst, pcsp, exp_f, pd_f;
  logic [31:0] rd;
  logic er;
  logic [4:0] k;
  logic [7:0] lk;
  logic [7:0] lv [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0};
  int err_total = 0;
  int comparisons = 0;
  int n_rst = 0;
  int n_pcsp = 0;
  int r0, p0, s;

  warc_top #(.SOFT_RESET_DELAY(SRD)) warc_top_i (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .apb_req(req),
    .apb_rsp(rsp), .slow_internal_osc(osc), .supply_low(sup),
    .cpu_evt(cpu), .device_reset(dev_rst), .pc_sp_reset(pcsp),
    .expiry_flag(exp_f), .powerdown_flag(pd_f));

  always #25 clk = ~clk;

  // Count reset pulses so that scenarios can compare deltas.
  always @(posedge clk) begin
    if (arst_n && dev_rst === 1'b1) n_rst++;
    if (pcsp === 1'b1) n_pcsp++;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      $display("MISMATCH %0t bus answer missing", $time);
      test_done();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e, "read data");
  endtask : rdchk

  task automatic pulse(input logic clr, input logic hlt);
    cpu.clear_watchdog_instr <= clr;
    cpu.halt_instr <= hlt;
    @(posedge clk);
    cpu.clear_watchdog_instr <= 1'b0;
    cpu.halt_instr <= 1'b0;
    @(posedge clk);
  endtask : pulse

  // Slow oscillator periods; each level lasts four system clocks.
  task automatic slow(input int n);
    repeat (n) begin
      osc <= 1'b1;
      repeat (4) @(posedge clk);
      osc <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : slow

  function automatic int tout(input int code);
    int b [8] = '{8, 10, 12, 14, 15, 16, 17, 18};
    return 1 << b[code];
  endfunction : tout

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'hde93));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdchk(OFF_WDT_CTL, 32'h53);
    rdchk(OFF_LVL_KEY, 32'h66);
    rdchk(OFF_BO_WIDTH, 32'h1);
    rdchk(OFF_FLAGS, 32'h0);
    rdchk(OFF_STATUS, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    // Overflow must land exactly on the selected power of two.
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, OFF_WDT_CTL, {24'h0, 5'h0a, 3'(c)});
      pulse(1'b1, 1'b0);
      r0 = n_rst;
      slow(tout(c) - 1);
      chk(n_rst - r0, 0, "early overflow");
      slow(1);
      chk(n_rst - r0, 1, "overflow reset");
      chk({31'h0, exp_f}, 32'h1, "expiry flag");
      rdchk(OFF_WDT_CTL, 32'h53);
    end
    rdchk(OFF_STATUS, 32'h1);
    // Low-power overflow sets both flags and resets PC and SP, with no full reset.
    apb(1'b1, OFF_WDT_CTL, 32'h50);
    cpu.low_power <= 1'b1;
    pulse(1'b0, 1'b1);
    chk({30'h0, pd_f, exp_f}, 32'h2, "halt flags");
    r0 = n_rst;
    p0 = n_pcsp;
    slow(256);
    chk(n_rst - r0, 0, "low power full reset");
    chk(n_pcsp - p0, 1, "pc sp reset");
    rdchk(OFF_STATUS, 32'h3);
    rdchk(OFF_WDT_CTL, 32'h50);
    pulse(1'b1, 1'b0);
    chk({30'h0, pd_f, exp_f}, 32'h0, "clear flags");
    // A frozen block must ignore a halt pulse.
    clk_en <= 1'b0;
    pulse(1'b0, 1'b1);
    clk_en <= 1'b1;
    chk({31'h0, pd_f}, 32'h0, "halt while frozen");
    // Brownout qualification stays off in low power.
    apb(1'b1, OFF_WDT_CTL, 32'ha8);
    apb(1'b1, OFF_BO_WIDTH, 32'h0);
    sup <= 1'b1;
    slow(20);
    sup <= 1'b0;
    chk(n_rst - r0, 0, "brownout in low power");
    cpu.low_power <= 1'b0;
    slow(300);
    chk(n_rst - r0, 0, "disabled watchdog");
    // Invalid watchdog key: delayed reset and sticky flag.
    do k = 5'($urandom); while (k == 5'h0a || k == 5'h15);
    apb(1'b1, OFF_WDT_CTL, {24'h0, k, 3'($urandom)});
    slow(SRD + 2);
    chk(n_rst - r0, 1, "bad key reset");
    rdchk(OFF_FLAGS, 32'h1);
    rdchk(OFF_WDT_CTL, 32'h53);
    apb(1'b1, OFF_FLAGS, 32'h7);
    rdchk(OFF_FLAGS, 32'h1);
    apb(1'b1, OFF_FLAGS, 32'h0);
    rdchk(OFF_FLAGS, 32'h0);
    // Every valid level code is kept without a reset.
    apb(1'b1, OFF_WDT_CTL, 32'ha8);
    s = $urandom % 6;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFF_LVL_KEY, {24'h0, lv[(i + s) % 6]});
      slow(SRD + 2);
      rdchk(OFF_LVL_KEY, {24'h0, lv[(i + s) % 6]});
    end
    chk(n_rst - r0, 1, "valid level codes");
    do lk = 8'($urandom);
    while (lk inside {8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0});
    apb(1'b1, OFF_LVL_KEY, {24'h0, lk});
    slow(SRD + 2);
    chk(n_rst - r0, 2, "bad level reset");
    rdchk(OFF_FLAGS, 32'h2);
    rdchk(OFF_LVL_KEY, 32'h66);
    apb(1'b1, OFF_FLAGS, 32'h0);
    // Short supply dip is ignored, a long one resets.
    apb(1'b1, OFF_WDT_CTL, 32'ha8);
    apb(1'b1, OFF_LVL_KEY, 32'h55);
    sup <= 1'b1;
    slow(5);
    sup <= 1'b0;
    slow(4);
    chk(n_rst - r0, 2, "short dip");
    sup <= 1'b1;
    slow(10);
    sup <= 1'b0;
    slow(2);
    chk(n_rst - r0, 3, "brownout reset");
    rdchk(OFF_FLAGS, 32'h4);
    rdchk(OFF_LVL_KEY, 32'h55);
    rdchk(OFF_BO_WIDTH, 32'h0);
    test_done();
  end

  // Cut a hang short well beyond the expected run length.
  initial begin
    #4000000;
    err_total++;
    $display("MISMATCH %0t run did not finish", $time);
    test_done();
  end
endmodule : warc_tb
